//--- core/rx_per_channel_ctrl.sv
`timescale 1ns/100ps
module rx_per_channel_ctrl
    import rx_per_channel_ctrl_pkg::*;
#(
    parameter int        NUM_CHAN  = 24,
    parameter reg_byte_t MW_BYTE_0 = 8'h1e,
    parameter reg_byte_t MW_BYTE_1 = 8'h0b,
    parameter reg_byte_t MW_BYTE_2 = 8'h0b,
    parameter reg_byte_t MW_BYTE_3 = 8'h1e,
    parameter reg_byte_t MW_BYTE_4 = 8'h9e,
    parameter reg_byte_t MW_BYTE_5 = 8'h8b,
    parameter reg_byte_t MW_BYTE_6 = 8'h8b,
    parameter reg_byte_t MW_BYTE_7 = 8'h9e
)
(
    input  wire logic       i_clock,
    input  wire logic       i_reset_n,
    input  wire logic [7:0] i_bus_addr,
    input  wire logic       i_bus_wr,
    input  wire logic       i_bus_rd,
    input  wire reg_byte_t  i_bus_wdata,
    output reg_byte_t       o_bus_rdata,
    input  wire logic       i_bit_strobe,
    input  wire logic       i_frame_bit,
    input  wire logic       i_rx_pcm,
    input  wire logic       i_rx_sig,
    output logic            o_backplane_rx_pcm_out,
    output logic            o_backplane_rx_sig_out,
    output logic            o_access_busy
);
    `include "rx_per_channel_ctrl_params.svh"

    // reset image of the configuration byte
    localparam reg_byte_t CONFIG_RESET = `RESET_CONFIG;

    // register file state
    logic            per_channel_func_enable;
    logic            indirect_access_select;
    reg_byte_t       indirect_address_control;
    reg_byte_t       indirect_data_buffer;
    logic            busy;

    // indirect access engine
    access_state_t   state;
    access_state_t   next_state;
    logic [4:0]      wait_count;
    map_addr_t       acc_addr;
    logic            acc_read;
    logic            acc_valid;
    logic [1:0]      acc_bank;
    logic [4:0]      acc_offset;
    reg_byte_t       acc_rdata;
    logic            acc_finish;
    logic            mem_write;
    logic            read_done;

    // control memory, one bank per map region
    reg_byte_t       ctl_mem   [0:NUM_CHAN-1];
    reg_byte_t       trunk_mem [0:NUM_CHAN-1];
    reg_byte_t       sig_mem   [0:NUM_CHAN-1];

    // stream position
    logic [2:0]      bit_pos;
    logic [4:0]      chan;
    logic [2:0]      mw_phase;
    logic            chan_ok;
    reg_byte_t       ctl_byte;
    reg_byte_t       trunk_byte;
    reg_byte_t       sig_byte;
    reg_byte_t       mw_byte;
    logic            proc_pcm;
    logic            proc_sig;

    // bus decode
    logic            wr_config;
    logic            wr_addr_ctrl;
    logic            wr_data_buf;
    logic            start_access;
    reg_byte_t       next_bus_rdata;

    always_comb begin
        wr_config    = 1'b0;
        wr_addr_ctrl = 1'b0;
        wr_data_buf  = 1'b0;
        if (i_bus_wr) begin
            if (i_bus_addr == `OFS_PER_CHANNEL_CONFIG) begin
                wr_config = 1'b1;
            end else if (i_bus_addr == `OFS_INDIRECT_ADDRESS_CONTROL) begin
                wr_addr_ctrl = 1'b1;
            end else if (i_bus_addr == `OFS_INDIRECT_DATA_BUFFER) begin
                wr_data_buf = 1'b1;
            end
        end
    end

    // a request is refused while indirect access is disabled or one is pending
    assign start_access = wr_addr_ctrl && indirect_access_select && !busy; // [RULE2] [RULE6]

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            per_channel_func_enable <= CONFIG_RESET[`BIT_FUNC_ENABLE];
            indirect_access_select  <= CONFIG_RESET[`BIT_INDIRECT_SEL]; // [RULE2]
        end else if (wr_config) begin
            per_channel_func_enable <= i_bus_wdata[`BIT_FUNC_ENABLE];
            indirect_access_select  <= i_bus_wdata[`BIT_INDIRECT_SEL];
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            indirect_address_control <= `RESET_ADDR_CTRL;
        end else if (wr_addr_ctrl && !busy) begin
            indirect_address_control <= i_bus_wdata;
        end
    end

    // completion of a read wins over a host write in the same cycle
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            indirect_data_buffer <= `RESET_DATA_BUF;
        end else if (read_done) begin
            indirect_data_buffer <= acc_rdata; // [RULE9]
        end else if (wr_data_buf) begin
            indirect_data_buffer <= i_bus_wdata; // [RULE8]
        end
    end

    // access sequencer
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_access) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (wait_count == 5'h00) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wait_count <= 5'h00;
        end else if (start_access) begin
            wait_count <= 5'(`ACCESS_WAIT_CYCLES - 1); // [RULE5]
        end else if (state == ST_WAIT && wait_count != 5'h00) begin
            wait_count <= wait_count - 5'h01;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            acc_addr <= 7'h00;
            acc_read <= 1'b0;
        end else if (start_access) begin
            acc_addr <= i_bus_wdata[6:0]; // [RULE6]
            acc_read <= i_bus_wdata[`BIT_READ_NOT_WRITE]; // [RULE7]
        end
    end

    // busy clears on the same edge that performs the access
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            busy <= 1'b0;
        end else if (start_access) begin
            busy <= 1'b1; // [RULE3]
        end else if (acc_finish) begin
            busy <= 1'b0; // [RULE3]
        end
    end

    assign acc_finish = (state == ST_DONE);
    assign read_done  = acc_finish && acc_read;
    assign mem_write  = acc_finish && !acc_read;

    // address 00h and anything past 48h map to nothing; bank 3 marks them
    always_comb begin
        acc_bank   = 2'h3;
        acc_offset = 5'h00;
        if (acc_addr < `MAP_PCM_BASE) begin
            acc_bank = 2'h3;
        end else if (acc_addr < `MAP_DTRK_BASE) begin
            acc_bank   = 2'h0; // [RULE10]
            acc_offset = 5'(acc_addr - `MAP_PCM_BASE);
        end else if (acc_addr < `MAP_STRK_BASE) begin
            acc_bank   = 2'h1; // [RULE10]
            acc_offset = 5'(acc_addr - `MAP_DTRK_BASE);
        end else if (acc_addr <= `MAP_LAST) begin
            acc_bank   = 2'h2; // [RULE10]
            acc_offset = 5'(acc_addr - `MAP_STRK_BASE);
        end
    end

    assign acc_valid = (acc_bank != 2'h3);

    always_comb begin
        acc_rdata = 8'h00;
        if (acc_bank == 2'h0) begin
            acc_rdata = ctl_mem[acc_offset];
        end else if (acc_bank == 2'h1) begin
            acc_rdata = trunk_mem[acc_offset];
        end else if (acc_bank == 2'h2) begin
            acc_rdata = sig_mem[acc_offset];
        end
    end

    // writes outside the map are dropped
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                ctl_mem[i]   <= `RESET_MAP_BYTE;
                trunk_mem[i] <= `RESET_MAP_BYTE;
                sig_mem[i]   <= `RESET_MAP_BYTE;
            end
        end else if (mem_write && acc_valid) begin
            if (acc_bank == 2'h0) begin
                ctl_mem[acc_offset] <= indirect_data_buffer; // [RULE7] [RULE10]
            end else if (acc_bank == 2'h1) begin
                trunk_mem[acc_offset] <= indirect_data_buffer; // [RULE7] [RULE10]
            end else if (acc_bank == 2'h2) begin
                sig_mem[acc_offset] <= indirect_data_buffer; // [RULE7] [RULE10]
            end
        end
    end

    // register read port
    always_comb begin
        next_bus_rdata = 8'h00;
        if (i_bus_addr == `OFS_PER_CHANNEL_CONFIG) begin
            next_bus_rdata = {6'h00, indirect_access_select, per_channel_func_enable};
        end else if (i_bus_addr == `OFS_INDIRECT_ACCESS_STATUS) begin
            next_bus_rdata = {busy, 7'h00}; // [RULE3]
        end else if (i_bus_addr == `OFS_INDIRECT_ADDRESS_CONTROL) begin
            next_bus_rdata = indirect_address_control;
        end else if (i_bus_addr == `OFS_INDIRECT_DATA_BUFFER) begin
            next_bus_rdata = indirect_data_buffer;
        end
    end

    // read data holds until the next read strobe
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_bus_rdata <= 8'h00;
        end else if (i_bus_rd) begin
            o_bus_rdata <= next_bus_rdata;
        end
    end

    assign o_access_busy = busy;

    // stream position: frame bit restarts channel 1 and steps the milliwatt phase
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bit_pos <= 3'h0;
            chan    <= 5'h00;
        end else if (i_bit_strobe) begin
            if (i_frame_bit) begin
                bit_pos <= 3'h0;
                chan    <= 5'h00;
            end else begin
                bit_pos <= bit_pos + 3'h1;
                if (bit_pos == 3'h7 && chan_ok) begin
                    chan <= chan + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mw_phase <= 3'h0;
        end else if (i_bit_strobe && i_frame_bit) begin
            mw_phase <= mw_phase + 3'h1;
        end
    end

    // extra bits before the next frame bit pass untouched
    assign chan_ok = (chan < 5'(NUM_CHAN));

    always_comb begin
        ctl_byte   = 8'h00;
        trunk_byte = 8'h00;
        sig_byte   = 8'h00;
        if (chan_ok) begin
            ctl_byte   = ctl_mem[chan];
            trunk_byte = trunk_mem[chan];
            sig_byte   = sig_mem[chan];
        end
    end

    always_comb begin
        case (mw_phase)
            3'h0: mw_byte = MW_BYTE_0;
            3'h1: mw_byte = MW_BYTE_1;
            3'h2: mw_byte = MW_BYTE_2;
            3'h3: mw_byte = MW_BYTE_3;
            3'h4: mw_byte = MW_BYTE_4;
            3'h5: mw_byte = MW_BYTE_5;
            3'h6: mw_byte = MW_BYTE_6;
            default: mw_byte = MW_BYTE_7;
        endcase
    end

    pcm_bit_proc u_bit_proc (
        .i_bit_pos    (bit_pos),
        .i_pcm_bit    (i_rx_pcm),
        .i_sig_bit    (i_rx_sig),
        .i_func_en    (per_channel_func_enable && chan_ok && !i_frame_bit),
        .i_ctl_byte   (ctl_byte),
        .i_trunk_byte (trunk_byte),
        .i_sig_byte   (sig_byte),
        .i_mw_byte    (mw_byte),
        .o_pcm_bit    (proc_pcm),
        .o_sig_bit    (proc_sig)
    );

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_backplane_rx_pcm_out <= 1'b0;
            o_backplane_rx_sig_out <= 1'b0;
        end else if (i_bit_strobe) begin
            o_backplane_rx_pcm_out <= proc_pcm; // [RULE1] [RULE17]
            o_backplane_rx_sig_out <= proc_sig; // [RULE1]
        end
    end

endmodule : rx_per_channel_ctrl

//--- include/rx_per_channel_ctrl_params.svh
// Contract
// [RULE1] Channel byte functions act only with the function enable set; otherwise bypass.
// [RULE2] Indirect select resets to 0; software sets it before any indirect access.
// [RULE3] Busy reads 1 while an access is pending, drops on a clock edge after.
// [RULE4] Host polls busy until 0 before starting the next indirect access.
// [RULE5] An indirect access completes within 640 ns of its start.
// [RULE6] Writing address/control starts an access at the seven-bit address given.
// [RULE7] Direction bit 1 requests a read, 0 requests a write.
// [RULE8] Host loads the data buffer before writing the address with direction 0.
// [RULE9] A read places the addressed byte in the data buffer within 640 ns.
// [RULE10] Map holds 24 control, 24 data trunk, 24 signalling bytes from 01h.
// [RULE11] Full inversion complements every bit of the channel byte.
// [RULE12] Sign inversion complements only the channel byte's most significant bit.
// [RULE13] Both inversions together complement all bits except the most significant.
// [RULE14] Data trunk select replaces the channel byte with the stored trunk byte.
// [RULE15] Milliwatt select replaces the channel byte with the milliwatt pattern.
// [RULE16] Milliwatt beats trunk conditioning, which beats any inversion.
// [RULE17] Channel functions do not depend on the framing format.
// [RULE18] Trunk byte leaves most significant bit first, least significant last.
// [RULE19] Signalling trunk select puts the stored four-bit code in the low nibble.
`ifndef RX_PER_CHANNEL_CTRL_PARAMS_SVH
`define RX_PER_CHANNEL_CTRL_PARAMS_SVH

`define OFS_PER_CHANNEL_CONFIG       8'h50
`define OFS_INDIRECT_ACCESS_STATUS   8'h51
`define OFS_INDIRECT_ADDRESS_CONTROL 8'h52
`define OFS_INDIRECT_DATA_BUFFER     8'h53

`define BIT_FUNC_ENABLE   0
`define BIT_INDIRECT_SEL  1
`define BIT_BUSY          7
`define BIT_READ_NOT_WRITE 7

`define CTL_FULL_INVERT   7
`define CTL_DATA_TRUNK    6
`define CTL_MILLIWATT     5
`define CTL_SIGN_FLIP     4
`define SIG_TRUNK_SELECT  7

`define MAP_PCM_BASE      7'h01
`define MAP_DTRK_BASE     7'h19
`define MAP_STRK_BASE     7'h31
`define MAP_LAST          7'h48

`define RESET_CONFIG      8'h00
`define RESET_ADDR_CTRL   8'h00
`define RESET_DATA_BUF    8'h00
`define RESET_MAP_BYTE    8'h00

`define CLOCK_MHZ         40
`define ACCESS_MAX_NS     640
`define ACCESS_MAX_CYCLES ((`ACCESS_MAX_NS * `CLOCK_MHZ) / 1000)
`define ACCESS_WAIT_CYCLES 4

`endif

//--- include/rx_per_channel_ctrl_pkg.sv
package rx_per_channel_ctrl_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_DONE
    } access_state_t;

    typedef logic [7:0] reg_byte_t;
    typedef logic [6:0] map_addr_t;

endpackage : rx_per_channel_ctrl_pkg

//--- core/pcm_bit_proc.sv
`timescale 1ns/100ps
module pcm_bit_proc
    import rx_per_channel_ctrl_pkg::*;
(
    input  wire logic [2:0] i_bit_pos,
    input  wire logic       i_pcm_bit,
    input  wire logic       i_sig_bit,
    input  wire logic       i_func_en,
    input  wire reg_byte_t  i_ctl_byte,
    input  wire reg_byte_t  i_trunk_byte,
    input  wire reg_byte_t  i_sig_byte,
    input  wire reg_byte_t  i_mw_byte,
    output logic            o_pcm_bit,
    output logic            o_sig_bit
);
    `include "rx_per_channel_ctrl_params.svh"

    logic       is_msb;
    logic [2:0] sel;
    logic       flip;

    // position 0 is the first bit out, the msb
    assign is_msb = (i_bit_pos == 3'h0);
    assign sel    = 3'h7 - i_bit_pos;

    // one flip term covers full, sign and magnitude inversion
    assign flip = i_ctl_byte[`CTL_FULL_INVERT] ^ (i_ctl_byte[`CTL_SIGN_FLIP] & is_msb); // [RULE11] [RULE12] [RULE13]

    always_comb begin
        o_pcm_bit = i_pcm_bit;
        o_sig_bit = i_sig_bit;
        if (i_func_en) begin // [RULE1] [RULE17]
            if (i_ctl_byte[`CTL_MILLIWATT]) begin // [RULE16]
                o_pcm_bit = i_mw_byte[sel]; // [RULE15]
            end else if (i_ctl_byte[`CTL_DATA_TRUNK]) begin // [RULE16]
                o_pcm_bit = i_trunk_byte[sel]; // [RULE14] [RULE18]
            end else begin
                o_pcm_bit = i_pcm_bit ^ flip;
            end
            if (i_sig_byte[`SIG_TRUNK_SELECT] && i_bit_pos[2]) begin
                o_sig_bit = i_sig_byte[sel]; // [RULE19]
            end
        end
    end

endmodule : pcm_bit_proc

//--- test/rx_per_channel_ctrl_monitor.sv
`timescale 1ns/100ps
module rx_per_channel_ctrl_monitor
    import rx_per_channel_ctrl_pkg::*;
(
    input wire logic       i_clock,
    input wire logic       i_reset_n,
    input wire logic [7:0] i_bus_addr,
    input wire logic       i_bus_wr,
    input wire logic       i_bus_rd,
    input wire reg_byte_t  i_bus_wdata,
    input wire reg_byte_t  o_bus_rdata,
    input wire logic       i_bit_strobe,
    input wire logic       i_frame_bit,
    input wire logic       i_rx_pcm,
    input wire logic       o_backplane_rx_pcm_out,
    input wire logic       o_access_busy
);
    logic [1:0] cfg;
    logic       wr52;
    assign wr52 = i_bus_wr && i_bus_addr == 8'h52 && !o_access_busy;
    // shadow of enable and select bits
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cfg <= 2'h0;
        end else if (i_bus_wr && i_bus_addr == 8'h50) begin
            cfg <= i_bus_wdata[1:0];
        end
    end
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);
    property p_start;
        wr52 && cfg[1] |=> o_access_busy;
    endproperty
    a_start: assert property (p_start) else $error("access not started");
    property p_no_sel;
        wr52 && !cfg[1] |=> !o_access_busy;
    endproperty
    a_no_sel: assert property (p_no_sel) else $error("access without select");
    property p_pending;
        $rose(o_access_busy) |-> o_access_busy[*4];
    endproperty
    a_pending: assert property (p_pending) else $error("busy dropped early");
    property p_bound;
        $rose(o_access_busy) |-> ##[1:25] !o_access_busy;
    endproperty
    a_bound: assert property (p_bound) else $error("access too long");
    property p_cfg_rd;
        i_bus_rd && i_bus_addr == 8'h50 |=> o_bus_rdata == {6'h00, cfg};
    endproperty
    a_cfg_rd: assert property (p_cfg_rd) else $error("config readback");
    property p_bypass;
        i_bit_strobe && !cfg[0] |=> o_backplane_rx_pcm_out == $past(i_rx_pcm);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass altered bit");
    property p_frame;
        i_bit_strobe && i_frame_bit |=> o_backplane_rx_pcm_out == $past(i_rx_pcm);
    endproperty
    a_frame: assert property (p_frame) else $error("frame bit altered");
    property p_hold;
        !i_bit_strobe |=> $stable(o_backplane_rx_pcm_out);
    endproperty
    a_hold: assert property (p_hold) else $error("output moved off strobe");
endmodule : rx_per_channel_ctrl_monitor

//--- test/pcm_feed.sv
`timescale 1ns/100ps
module pcm_feed (
    input  wire logic i_clock,
    input  wire logic i_run,
    output logic      o_strobe,
    output logic      o_frame,
    output logic      o_pcm,
    output logic      o_sig
);
    initial begin
        {o_strobe, o_frame, o_pcm, o_sig} = 4'h0;
        forever begin
            @(negedge i_clock);
            // whole frames only: frame bit then 24 bytes
            if (i_run) begin
                for (int n = 0; n < 193; n++) begin
                    o_strobe <= 1'b1;
                    o_frame  <= (n == 0);
                    o_pcm    <= 1'($urandom);
                    o_sig    <= 1'($urandom);
                    @(negedge i_clock);
                    o_strobe <= 1'b0;
                    o_frame  <= 1'b0;
                    // no stale bit between strobes
                    repeat (3) begin
                        o_pcm <= ~o_pcm;
                        o_sig <= ~o_sig;
                        @(negedge i_clock);
                    end
                end
            end
        end
    end
endmodule : pcm_feed

//--- test/rx_per_channel_ctrl_tb_top.sv
`timescale 1ns/100ps
module rx_per_channel_ctrl_tb_top
    import rx_per_channel_ctrl_pkg::*;
;
    logic       i_clock, i_reset_n, i_bus_wr, i_bus_rd, i_bit_strobe, i_frame_bit;
    logic       i_rx_pcm, i_rx_sig, o_backplane_rx_pcm_out, o_backplane_rx_sig_out;
    logic       o_access_busy, run, en, fr, pb, sb;
    logic [7:0] i_bus_addr;
    reg_byte_t  i_bus_wdata, o_bus_rdata, q, ib, ob, si, so;
    reg_byte_t  mp [0:127];
    int         num_errors, tests_run, chan, bitn, n, nf;
    // milliwatt pattern, one byte per frame
    reg_byte_t  mw_pat [0:7] = '{8'h1e, 8'h0b, 8'h0b, 8'h1e, 8'h9e, 8'h8b, 8'h8b, 8'h9e};

    rx_per_channel_ctrl rx_per_channel_ctrl_i (
        .i_clock(i_clock), .i_reset_n(i_reset_n), .i_bus_addr(i_bus_addr),
        .i_bus_wr(i_bus_wr), .i_bus_rd(i_bus_rd), .i_bus_wdata(i_bus_wdata),
        .o_bus_rdata(o_bus_rdata), .i_bit_strobe(i_bit_strobe), .i_frame_bit(i_frame_bit),
        .i_rx_pcm(i_rx_pcm), .i_rx_sig(i_rx_sig), .o_access_busy(o_access_busy),
        .o_backplane_rx_pcm_out(o_backplane_rx_pcm_out),
        .o_backplane_rx_sig_out(o_backplane_rx_sig_out)
    );
    pcm_feed pcm_feed_i (
        .i_clock(i_clock), .i_run(run), .o_strobe(i_bit_strobe),
        .o_frame(i_frame_bit), .o_pcm(i_rx_pcm), .o_sig(i_rx_sig)
    );

    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : check

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done

    task automatic bus(input logic w, input logic [7:0] a, input reg_byte_t d);
        @(negedge i_clock);
        {i_bus_wr, i_bus_rd, i_bus_addr, i_bus_wdata} = {w, !w, a, d};
        @(negedge i_clock);
        {i_bus_wr, i_bus_rd} = 2'h0;
        @(negedge i_clock);
    endtask : bus

    task automatic ia(input logic r, input logic [6:0] a, input reg_byte_t d);
        if (!r) bus(1'b1, 8'h53, d);
        bus(1'b1, 8'h52, {r, a});
        check(o_access_busy, "busy low");
        n = 0;
        do begin
            bus(1'b0, 8'h51, 8'h00);
            n += 3;
        end while (o_bus_rdata !== 8'h00 && n < 60);
        check(n <= 27, "access slow");
        bus(1'b0, 8'h53, 8'h00);
        q = o_bus_rdata;
    endtask : ia

    task automatic frames(input int k);
        @(posedge i_clock);
        run = 1'b1;
        repeat (k) @(posedge i_frame_bit);
        run = 1'b0;
        repeat (800) @(negedge i_clock);
    endtask : frames

    function automatic reg_byte_t pcm_exp(input int c, input reg_byte_t d);
        if (!en) return d;
        if (mp[c][6]) return mp[c + 24];
        return d ^ {8{mp[c][7]}} ^ {mp[c][4], 7'h00};
    endfunction : pcm_exp

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // gather each channel byte from the serial stream
    always @(posedge i_clock) begin
        if (i_bit_strobe === 1'b1) begin
            {fr, pb, sb} = {i_frame_bit, i_rx_pcm, i_rx_sig};
            @(negedge i_clock);
            @(negedge i_clock);
            if (fr) begin
                check({o_backplane_rx_pcm_out, o_backplane_rx_sig_out} === {pb, sb},
                      "frame");
                chan = 1;
                bitn = 0;
                nf++;
            end else if (chan > 0 && chan < 25) begin
                ib = {ib[6:0], pb};
                ob = {ob[6:0], o_backplane_rx_pcm_out};
                si = {si[6:0], sb};
                so = {so[6:0], o_backplane_rx_sig_out};
                bitn++;
                if (bitn == 8) begin
                    if (en && mp[chan][5]) check(ob === mw_pat[nf % 8], "mw");
                    else check(ob === pcm_exp(chan, ib), "pcm byte");
                    q = mp[chan + 48];
                    check(so === (en && q[7] ? {si[7:4], q[3:0]} : si), "sig byte");
                    chan++;
                    bitn = 0;
                end
            end
        end
    end

    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end

    initial begin
        repeat (40000) @(posedge i_clock);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        {i_reset_n, i_bus_wr, i_bus_rd, run, en} = 5'h00;
        {i_bus_addr, i_bus_wdata} = 16'h0000;
        void'($urandom(558));
        repeat (4) @(negedge i_clock);
        i_reset_n = 1'b1;
        for (int a = 8'h50; a < 8'h55; a++) begin
            bus(1'b0, 8'(a), 8'h00);
            check(o_bus_rdata === 8'h00, "reset value");
        end
        done("reset");
        bus(1'b1, 8'h52, 8'h05);
        check(o_access_busy === 1'b0, "access without select");
        bus(1'b0, 8'h52, 8'h00);
        check(o_bus_rdata === 8'h05, "address register");
        done("select off");
        bus(1'b1, 8'h50, 8'h02);
        for (int a = 0; a < 74; a++) begin
            mp[a] = 8'($urandom);
            if (a > 0 && a < 17) mp[a][7:4] = 4'(a - 1);
            ia(1'b0, 7'(a), mp[a]);
        end
        for (int a = 0; a < 74; a++) begin
            ia(1'b1, 7'(a), 8'h00);
            check(q === (a > 0 && a < 73 ? mp[a] : 8'h00), "map read");
        end
        done("map");
        frames(2);
        done("bypass");
        en = 1'b1;
        bus(1'b1, 8'h50, 8'h03);
        frames(3);
        done("channel functions");
        tally_and_finish();
    end
endmodule : rx_per_channel_ctrl_tb_top

bind rx_per_channel_ctrl rx_per_channel_ctrl_monitor rx_per_channel_ctrl_monitor_i (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_bus_addr(i_bus_addr),
    .i_bus_wr(i_bus_wr), .i_bus_rd(i_bus_rd), .i_bus_wdata(i_bus_wdata),
    .o_bus_rdata(o_bus_rdata), .i_bit_strobe(i_bit_strobe), .i_frame_bit(i_frame_bit),
    .i_rx_pcm(i_rx_pcm), .o_backplane_rx_pcm_out(o_backplane_rx_pcm_out),
    .o_access_busy(o_access_busy)
);
